// ===== rtl/byte_count_field.sv
// byte_count_field: two's complement buffer byte counter.
// assumes load and byte_fetched are single-cycle pulses from clk logic.
`timescale 1ns/10ps
module byte_count_field (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // fetch link
    fetch_if.cnt      f
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
        logic        exh;
        logic        zero;
    } st_type;
    st_type st_r;
    st_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.exh = 1'b0;
        st_nxt.zero = 1'b0;
        if (f.load) begin
            st_nxt.cnt = f.count_word;
            if (f.count_word == 16'h0000) begin
                st_nxt.zero = 1'b1;
            end else begin
                st_nxt.busy = 1'b1;
            end
        end else if (st_r.busy && f.byte_fetched) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (st_nxt.cnt == 16'h0000) begin
                st_nxt.busy = 1'b0;
                st_nxt.exh = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign f.busy = st_r.busy;
    assign f.exhausted = st_r.exh;
    assign f.zero_len = st_r.zero;

    stop_at_zero_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.busy && f.byte_fetched && !f.load && st_r.cnt == 16'hffff)
        |=> (!st_r.busy && st_r.exh))
        else $error("counter did not stop at zero");
    zero_no_fetch_a: assert property (@(posedge clk) disable iff (rst)
        (f.load && f.count_word == 16'h0000) |=> (st_r.zero && !st_r.busy))
        else $error("zero count started a fetch");
endmodule // byte_count_field

// ===== rtl/mac_deferral_heartbeat_txcount.sv
// mac_deferral_heartbeat_txcount: tx byte count, two-phase deferral, blinding, heartbeat test.
// assumes carrier and collision pins are asynchronous; wishbone master on clk.
`timescale 1ns/10ps
module mac_deferral_heartbeat_txcount (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // network side
    input  wire logic        rx_carrier_active,
    input  wire logic        collision,
    output logic             tx_drive_active,
    // buffer fetch
    output logic             byte_req,
    input  wire logic        byte_ack,
    output logic             own_clear,
    // interrupt
    output logic             irq
);
    localparam int unsigned pkg_w = mac_defer_pkg::cnt_w;
    typedef enum logic [2:0] {
        idle, phase_one, phase_two, ready, sending
    } def_type;
    typedef enum logic [1:0] {
        hb_off, hb_wait_drop, hb_open
    } hb_type;
    typedef struct packed {
        logic [1:0]  crs_s;
        logic [1:0]  col_s;
        logic        crs_q;
        def_type     dst;
        logic [pkg_w-1:0] dcnt;
        logic [pkg_w-1:0] blind;
        hb_type      hst;
        logic [pkg_w-1:0] hcnt;
        logic        collided;
        logic        pending;
        logic        fetching;
        logic        tx_on;
        logic        own_clr;
        logic [15:0] status;
        logic [15:0] mask;
        logic [15:0] count_word;
        logic        ack;
        logic [31:0] rdat;
    } st_type;

    st_type st_r;
    st_type st_nxt;
    fetch_if f ();

    byte_count_field u_cnt (
        .clk (clk),
        .rst (rst),
        .f   (f)
    );

    logic        crs;
    logic        col;
    logic        blinded;
    logic        rx_act;
    logic        bus_req;
    logic        go;
    logic [15:0] ev_set;
    assign crs = st_r.crs_s[1];
    assign col = st_r.col_s[1];
    assign blinded = st_r.blind != '0;
    assign rx_act = crs && !blinded;
    assign bus_req = cyc_i && stb_i && !st_r.ack;
    assign go = bus_req && we_i && adr_i == mac_defer_pkg::ctrl_off && sel_i[0] && dat_i[0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.crs_s = {st_r.crs_s[0], rx_carrier_active};
        st_nxt.col_s = {st_r.col_s[0], collision};
        st_nxt.crs_q = crs;
        st_nxt.own_clr = 1'b0;
        st_nxt.ack = bus_req;
        ev_set = 16'h0000;
        f.load = 1'b0;
        f.count_word = st_r.count_word;
        f.byte_fetched = st_r.fetching && byte_ack;
        if (st_r.blind != '0) begin
            st_nxt.blind = st_r.blind - pkg_w'(1);
        end
        // start of a transmit request
        if (go && !st_r.pending) begin
            f.load = 1'b1;
            st_nxt.pending = 1'b1;
        end
        if (f.zero_len) begin
            st_nxt.pending = 1'b0;
            st_nxt.own_clr = 1'b1;
            ev_set[mac_defer_pkg::zero_len_bit] = 1'b1;
        end
        if (f.busy) begin
            st_nxt.fetching = 1'b1;
        end
        if (f.exhausted) begin
            st_nxt.fetching = 1'b0;
        end
        // deferral
        unique case (st_r.dst)
            idle: begin
                if (rx_act) begin
                    st_nxt.dst = sending;
                end else begin
                    st_nxt.dst = phase_one;
                    st_nxt.dcnt = pkg_w'(mac_defer_pkg::phase_one_cyc);
                end
            end
            phase_one: begin
                if (rx_act) begin
                    st_nxt.dcnt = pkg_w'(mac_defer_pkg::phase_one_cyc);
                end else if (st_r.dcnt == pkg_w'(1)) begin
                    st_nxt.dst = phase_two;
                    st_nxt.dcnt = pkg_w'(mac_defer_pkg::phase_two_cyc);
                end else begin
                    st_nxt.dcnt = st_r.dcnt - pkg_w'(1);
                end
            end
            phase_two: begin
                if (st_r.dcnt == pkg_w'(1)) begin
                    st_nxt.dst = ready;
                end else begin
                    st_nxt.dcnt = st_r.dcnt - pkg_w'(1);
                end
            end
            ready: begin
                if (st_r.pending && !st_r.fetching && !f.busy && !f.load && !f.zero_len
                        && !rx_act) begin
                    st_nxt.dst = sending;
                    st_nxt.tx_on = 1'b1;
                    st_nxt.collided = 1'b0;
                end else if (rx_act) begin
                    st_nxt.dst = sending;
                end
            end
            sending: begin
                if (st_r.tx_on) begin
                    if (col) begin
                        st_nxt.collided = 1'b1;
                    end
                    if (!st_r.fetching && !f.busy) begin
                        st_nxt.tx_on = 1'b0;
                        st_nxt.pending = 1'b0;
                        st_nxt.own_clr = 1'b1;
                        ev_set[mac_defer_pkg::tx_done_bit] = 1'b1;
                        st_nxt.blind = pkg_w'(mac_defer_pkg::blind_tx_cyc);
                        st_nxt.dst = phase_one;
                        st_nxt.dcnt = pkg_w'(mac_defer_pkg::phase_one_cyc);
                        st_nxt.hst = hb_wait_drop;
                    end
                end else if (!crs) begin
                    st_nxt.blind = pkg_w'(mac_defer_pkg::blind_rx_cyc);
                    st_nxt.dst = phase_one;
                    st_nxt.dcnt = pkg_w'(mac_defer_pkg::phase_one_cyc);
                end
            end
            default: st_nxt.dst = idle;
        endcase
        // heartbeat test
        unique case (st_r.hst)
            hb_off: ;
            hb_wait_drop: begin
                if (st_r.collided) begin
                    st_nxt.hst = hb_off;
                end else if (st_r.crs_q && !crs) begin
                    st_nxt.hst = hb_open;
                    st_nxt.hcnt = pkg_w'(mac_defer_pkg::hb_window_cyc);
                end
            end
            hb_open: begin
                if (col) begin
                    st_nxt.hst = hb_off;
                end else if (st_r.hcnt == pkg_w'(1)) begin
                    st_nxt.hst = hb_off;
                    ev_set[mac_defer_pkg::heartbeat_fail_bit] = 1'b1;
                end else begin
                    st_nxt.hcnt = st_r.hcnt - pkg_w'(1);
                end
            end
            default: st_nxt.hst = hb_off;
        endcase
        // sticky status, a set in the same cycle as a read wins
        st_nxt.status = st_r.status | ev_set;
        // wishbone registers
        st_nxt.rdat = 32'h0000_0000;
        if (bus_req) begin
            unique case (adr_i)
                mac_defer_pkg::main_control_status_reg_off: begin
                    st_nxt.rdat = {16'h0000, st_r.status};
                    if (!we_i) begin
                        st_nxt.status = ev_set;
                    end
                end
                mac_defer_pkg::tx_desc_count_word_off: begin
                    st_nxt.rdat = {16'h0000, st_r.count_word};
                    if (we_i && !st_r.pending) begin
                        if (sel_i[0]) st_nxt.count_word[7:0] = dat_i[7:0];
                        if (sel_i[1]) st_nxt.count_word[15:8] = dat_i[15:8];
                    end
                end
                mac_defer_pkg::irq_mask_off: begin
                    st_nxt.rdat = {16'h0000, st_r.mask};
                    if (we_i) begin
                        if (sel_i[0]) st_nxt.mask[7:0] = dat_i[7:0];
                        if (sel_i[1]) st_nxt.mask[15:8] = dat_i[15:8];
                    end
                end
                mac_defer_pkg::ctrl_off: begin
                    st_nxt.rdat = {31'h0000_0000, st_r.pending};
                end
                default: st_nxt.rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dat_o = st_r.rdat;
    assign ack_o = st_r.ack;
    assign tx_drive_active = st_r.tx_on;
    assign byte_req = st_r.fetching;
    assign own_clear = st_r.own_clr;
    assign irq = |(st_r.status & st_r.mask);

    phase_reset_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.dst == phase_one && rx_act)
        |=> (st_r.dst == phase_one && st_r.dcnt == pkg_w'(mac_defer_pkg::phase_one_cyc)))
        else $error("carrier did not restart phase one");
    phase_two_run_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.dst == phase_two && st_r.dcnt > pkg_w'(1))
        |=> (st_r.dst == phase_two && st_r.dcnt == $past(st_r.dcnt) - pkg_w'(1)))
        else $error("phase two disturbed");
    start_send_a: assert property (@(posedge clk) disable iff (rst)
        $rose(st_r.tx_on) |-> $past(st_r.dst) == ready)
        else $error("transmit began outside ready");
    tx_defer_a: assert property (@(posedge clk) disable iff (rst)
        $fell(st_r.tx_on) |-> (st_r.dst == phase_one))
        else $error("no deferral after transmit");
    tx_blind_a: assert property (@(posedge clk) disable iff (rst)
        $fell(st_r.tx_on) |-> st_r.blind == pkg_w'(mac_defer_pkg::blind_tx_cyc))
        else $error("transmit blinding wrong");
    rx_blind_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.dst == sending && !st_r.tx_on && !crs)
        |=> st_r.blind == pkg_w'(mac_defer_pkg::blind_rx_cyc))
        else $error("receive blinding wrong");
    hb_open_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.hst == hb_wait_drop && !st_r.collided && st_r.crs_q && !crs)
        |=> (st_r.hst == hb_open && st_r.hcnt == pkg_w'(mac_defer_pkg::hb_window_cyc)))
        else $error("heartbeat window not opened");
    hb_skip_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.hst == hb_wait_drop && st_r.collided) |=> st_r.hst == hb_off)
        else $error("collided frame checked");
    hb_fail_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.hst == hb_open && st_r.hcnt == pkg_w'(1) && !col)
        |=> st_r.status[mac_defer_pkg::heartbeat_fail_bit])
        else $error("heartbeat failure not flagged");
    zero_own_a: assert property (@(posedge clk) disable iff (rst)
        f.zero_len |=> (own_clear && !tx_drive_active))
        else $error("zero buffer not released");
endmodule // mac_deferral_heartbeat_txcount

// ===== shared/fetch_if.sv
// fetch_if: byte-count load and fetch handshake between the main block and its counter.
// assumes both ends on clk.
`timescale 1ns/10ps
interface fetch_if;
    logic        load;
    logic [15:0] count_word;
    logic        byte_fetched;
    logic        busy;
    logic        exhausted;
    logic        zero_len;
    modport ctrl (output load, output count_word, output byte_fetched,
                  input busy, input exhausted, input zero_len);
    modport cnt  (input load, input count_word, input byte_fetched,
                  output busy, output exhausted, output zero_len);
endinterface

// ===== shared/mac_defer_pkg.sv
// mac_defer_pkg: constants used by the transmit timing block; its fetch counter uses none of them.
// assumes a single 40 MHz clock and classic wishbone register access.
package mac_defer_pkg;
    localparam int unsigned clk_mhz             = 40;
    // times in nanoseconds
    localparam int unsigned phase_one_ns        = 6000;
    localparam int unsigned phase_two_ns        = 3600;
    localparam int unsigned blind_tx_ns         = 4000;
    localparam int unsigned blind_rx_ns         = 400;
    localparam int unsigned hb_window_ns        = 4000;
    // cycle counts rounded to nearest, can round to zero
    localparam int unsigned phase_one_cyc = (phase_one_ns * clk_mhz + 500) / 1000;
    localparam int unsigned phase_two_cyc = (phase_two_ns * clk_mhz + 500) / 1000;
    localparam int unsigned blind_tx_cyc  = (blind_tx_ns * clk_mhz + 500) / 1000;
    localparam int unsigned blind_rx_cyc  = (blind_rx_ns * clk_mhz + 500) / 1000;
    localparam int unsigned hb_window_cyc = (hb_window_ns * clk_mhz + 500) / 1000;
    localparam int unsigned cnt_w         = 9;
    // register byte offsets
    localparam logic [3:0] main_control_status_reg_off = 4'h0;
    localparam logic [3:0] tx_desc_count_word_off      = 4'h4;
    localparam logic [3:0] irq_mask_off                = 4'h8;
    localparam logic [3:0] ctrl_off                    = 4'hc;
    // main status bit positions
    localparam int unsigned heartbeat_fail_bit = 13;
    localparam int unsigned zero_len_bit       = 1;
    localparam int unsigned tx_done_bit        = 0;
    localparam logic [15:0] status_rst = 16'h0000;
    localparam logic [15:0] mask_rst   = 16'h0000;
    localparam logic [15:0] count_rst  = 16'h0000;
endpackage

// ===== verif/tb.sv
// tb: register tests of tx byte count, deferral, blinding and heartbeat status.
// assumes xcvr_model on the network pins and one 40 MHz clock.
`timescale 1ns/10ps
module tb;
    localparam logic [3:0] st  = 4'h0;
    localparam logic [3:0] cw  = 4'h4;
    localparam logic [3:0] mk  = 4'h8;
    localparam logic [3:0] ct  = 4'hc;
    localparam int         gap = 384; // 6.0 us plus 3.6 us at 25 ns
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        cyc_i    = 1'b0;
    logic        stb_i    = 1'b0;
    logic        we_i     = 1'b0;
    logic [3:0]  adr_i    = 4'h0;
    logic [31:0] dat_i    = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o, carrier, coll, tx, byte_req, own_clear, irq;
    logic        byte_ack = 1'b0;
    logic        hb_en    = 1'b1;
    logic        jam_en   = 1'b0;
    logic        rx_go    = 1'b0;
    logic [7:0]  rx_len   = 8'h00;
    logic        tx_q     = 1'b0;
    int          err_total = 0;
    int          checks    = 0;
    int          cyc_n     = 0;
    int          acks      = 0;
    int          oc_n      = 0;
    int          tx_n      = 0;
    int          t0, t1, a0;
    mac_deferral_heartbeat_txcount dut (
        .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_carrier_active(carrier), .collision(coll), .tx_drive_active(tx),
        .byte_req(byte_req), .byte_ack(byte_ack), .own_clear(own_clear), .irq(irq)
    );
    xcvr_model xcvr (
        .clk(clk), .rst(rst), .tx_drive_active(tx), .rx_carrier_active(carrier),
        .collision(coll), .hb_en(hb_en), .jam_en(jam_en), .rx_go(rx_go), .rx_len(rx_len)
    );
    always #12.5 clk = ~clk;
    // event counters and byte delivery on alternate cycles
    always @(posedge clk) begin
        cyc_n    <= cyc_n + 1;
        tx_q     <= tx;
        acks     <= acks + int'(byte_req & byte_ack);
        oc_n     <= oc_n + int'(own_clear);
        tx_n     <= tx_n + int'(tx & ~tx_q);
        byte_ack <= byte_req & ~byte_ack & ~rst;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk);
        while (ack_o !== 1'b1) @(posedge clk);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    task automatic send(input logic [15:0] n);
        wr(cw, {16'h0, n});
        wr(ct, 32'h1);
    endtask
    task automatic wait_tx(output int t);
        while (tx !== 1'b1) @(negedge clk);
        t = cyc_n;
        while (tx === 1'b1) @(negedge clk);
    endtask
    task automatic rx_frame(input logic [7:0] n);
        rx_len <= n;
        rx_go  <= 1'b1;
        @(posedge clk);
        rx_go  <= 1'b0;
    endtask
    task automatic drop(output int t);
        @(negedge clk);
        while (carrier === 1'b1) @(negedge clk);
        t = cyc_n;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        results;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdc(st, 32'h0);
        rdc(cw, 32'h0);
        rdc(mk, 32'h0);
        wr(4'h2, 32'hffff_ffff);
        rdc(4'h2, 32'h0);
        a0 = oc_n;
        send(16'h0000);
        while (oc_n == a0) @(negedge clk);
        repeat (20) @(posedge clk);
        check(32'(tx_n), 32'h0);
        rdc(st, 32'h2);
        rdc(st, 32'h0);
        wr(mk, 32'h2000);
        a0 = acks;
        send(16'hfffd);
        wait_tx(t0);
        check(32'(acks - a0), 32'h3);
        send(16'hffff);
        wait_tx(t1);
        rng(t1 - t0, gap, gap + 4);
        repeat (250) @(posedge clk);
        rdc(st, 32'h1);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        hb_en <= 1'b0;
        a0 = acks;
        send(16'hf000);
        wait_tx(t0);
        check(32'(acks - a0), 32'h1000);
        repeat (250) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rdc(st, 32'h2001);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        repeat (350) @(posedge clk);
        a0 = oc_n;
        send(16'h0000);
        while (oc_n == a0) @(negedge clk);
        repeat (20) @(posedge clk);
        check(32'(tx_n), 32'h3);
        rdc(st, 32'h2);
        jam_en <= 1'b1;
        send(16'hffff);
        wait_tx(t0);
        repeat (10) @(posedge clk);
        jam_en <= 1'b0;
        repeat (250) @(posedge clk);
        rdc(st, 32'h1);
        hb_en <= 1'b1;
        repeat (600) @(posedge clk);
        rx_frame(8'h32);
        send(16'hffff);
        drop(t0);
        repeat (100) @(posedge clk);
        rx_frame(8'h0a);
        drop(t0);
        wait_tx(t1);
        rng(t1 - t0, gap, gap + 24);
        repeat (600) @(posedge clk);
        rx_frame(8'h32);
        send(16'hffff);
        drop(t0);
        repeat (296) @(posedge clk);
        rx_frame(8'h0a);
        wait_tx(t1);
        rng(t1 - t0, gap, gap + 36);
        results;
    end
endmodule // tb

// ===== verif/xcvr_model.sv
// xcvr_model: transceiver on the network pins: carrier echo, jam, heartbeat pulse.
// assumes bench control inputs change just after rising clk edges.
`timescale 1ns/10ps
module xcvr_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // network pins
    input  wire logic       tx_drive_active,
    output logic            rx_carrier_active,
    output logic            collision,
    // bench control
    input  wire logic       hb_en,
    input  wire logic       jam_en,
    input  wire logic       rx_go,
    input  wire logic [7:0] rx_len
);
    logic       tx_q;
    logic [7:0] car_n;
    logic [7:0] hb_n;
    assign rx_carrier_active = (car_n != 8'h00);
    // test pulse from 1.0 to 1.5 us after transmit end
    assign collision = jam_en | (hb_en & (hb_n >= 8'h28) & (hb_n < 8'h3c));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_q  <= 1'b0;
            car_n <= 8'h00;
            hb_n  <= 8'h00;
        end else begin
            tx_q <= tx_drive_active;
            if (tx_drive_active & ~tx_q)
                car_n <= jam_en ? 8'h1e : 8'h04;
            else if (rx_go)
                car_n <= rx_len;
            else if (car_n != 8'h00)
                car_n <= car_n - 8'h01;
            if (~tx_drive_active & tx_q)
                hb_n <= 8'h01;
            else if (hb_n != 8'h00 && hb_n != 8'h3c)
                hb_n <= hb_n + 8'h01;
            else
                hb_n <= 8'h00;
        end
    end
endmodule // xcvr_model
